// *** dpsc_pkg.sv ***
// Constants shared by the drive power state controller
package dpsc_pkg;
    // Clock rate
    localparam int unsigned CLK_MHZ = 250;
    // Automatic power-down inactivity time and spindle spin-up time
    localparam int unsigned APD_TIME_US = 1000;
    localparam int unsigned APD_CYCLES = APD_TIME_US * CLK_MHZ;
    localparam int unsigned SPINUP_TIME_US = 1000;
    localparam int unsigned SPINUP_CYCLES = SPINUP_TIME_US * CLK_MHZ;
    localparam int unsigned CNT_W = 32;
    // Power command opcodes
    localparam logic [7:0] OP_IDLE = 8'hE3;
    localparam logic [7:0] OP_IDLE_ALT = 8'h97;
    localparam logic [7:0] OP_IDLE_IMM = 8'hE1;
    localparam logic [7:0] OP_IDLE_IMM_ALT = 8'h95;
    localparam logic [7:0] OP_STBY = 8'hE2;
    localparam logic [7:0] OP_STBY_ALT = 8'h96;
    localparam logic [7:0] OP_STBY_IMM = 8'hE0;
    localparam logic [7:0] OP_STBY_IMM_ALT = 8'h94;
    localparam logic [7:0] OP_SLEEP = 8'hE6;
    localparam logic [7:0] OP_SLEEP_ALT = 8'h99;
    localparam logic [7:0] OP_CHECK = 8'hE5;
    localparam logic [7:0] OP_CHECK_ALT = 8'h98;
    // Reported power state codes
    localparam logic [2:0] PS_ACTIVE = 3'h0;
    localparam logic [2:0] PS_IDLE = 3'h1;
    localparam logic [2:0] PS_STANDBY = 3'h2;
    localparam logic [2:0] PS_SPINUP = 3'h3;
    localparam logic [2:0] PS_SLEEP = 3'h4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_IDLE,
        ST_STANDBY,
        ST_SPINUP,
        ST_SLEEP
    } dpsc_state_e;
endpackage

// *** dpsc_timer_if.sv ***
// Link between the state controller and the power-down timer
`timescale 1ns/100ps
`default_nettype none
interface dpsc_timer_if;
    logic restart;
    logic enable;
    logic expired;
    modport ctrl (output restart, output enable, input expired);
    modport timer (input restart, input enable, output expired);
endinterface
`default_nettype wire

// *** dpsc_idle_timer.sv ***
// Automatic power-down inactivity timer
`timescale 1ns/100ps
`default_nettype none
module dpsc_idle_timer #(
    parameter logic [dpsc_pkg::CNT_W-1:0] LIMIT =
        dpsc_pkg::CNT_W'(dpsc_pkg::APD_CYCLES)
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Controller link
    dpsc_timer_if.timer tmr
);
    logic [dpsc_pkg::CNT_W-1:0] cnt_q;
    logic [dpsc_pkg::CNT_W-1:0] cnt_d;
    logic exp_q;
    logic exp_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        // Any activity or a disabled timer starts the count over
        if (tmr.restart || !tmr.enable) begin
            cnt_d = dpsc_pkg::CNT_ZERO;
        end else if (cnt_q >= LIMIT - dpsc_pkg::CNT_ONE) begin
            cnt_d = dpsc_pkg::CNT_ZERO;
            exp_d = 1'b1;
        end else begin
            cnt_d = cnt_q + dpsc_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_q <= dpsc_pkg::CNT_ZERO;
            exp_q <= 1'b0;
        end else if (clk_en_i) begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign tmr.expired = exp_q;
endmodule // dpsc_idle_timer
`default_nettype wire

// *** dpsc_power_ctrl.sv ***
// Drive power state controller: active, idle, standby and sleep
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Four power states: active plus reduced idle, standby and sleep.
// - Any seek, read or write command moves the drive to active.
// - Idle powers part of the circuitry down but still takes commands.
// - IDLE or IDLE IMMEDIATE from active or standby enters idle.
// - In idle, resets, idle commands and non-media commands keep idle.
// - Standby powers down the actuator motor circuit and stops spindle.
// - Standby accepts commands; media commands wait for spindle spin-up.
// - STANDBY or STANDBY IMMEDIATE from active or idle enters standby.
// - Enabled power-down timer expiring moves the drive to standby.
// - In standby, resets, standby, check and non-media commands keep it.
// - SLEEP command enters sleep, the lowest power state.
// - In sleep every command is invalid and ignored.
// - Only a hardware or software reset leaves sleep, into standby.
// - Power commands are idle, standby variants, sleep, check mode.
module dpsc_power_ctrl #(
    parameter logic [dpsc_pkg::CNT_W-1:0] APD_CYCLES =
        dpsc_pkg::CNT_W'(dpsc_pkg::APD_CYCLES),
    parameter logic [dpsc_pkg::CNT_W-1:0] SPINUP_CYCLES =
        dpsc_pkg::CNT_W'(dpsc_pkg::SPINUP_CYCLES)
) (
    // Clock, power-on reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Drive resets from the host
    input wire logic hw_reset_i,
    input wire logic sw_reset_i,
    // Host command
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_media_i,
    // Power-down timer control
    input wire logic apd_enable_i,
    // Command results
    output logic cmd_done_o,
    output logic cmd_ignored_o,
    output logic busy_o,
    output logic mode_valid_o,
    output logic [2:0] mode_o,
    // Power controls and state
    output logic [2:0] power_state_o,
    output logic reduced_power_o,
    output logic actuator_motor_circuit_en_o,
    output logic spindle_run_o
);
    dpsc_timer_if tif ();

    dpsc_idle_timer #(
        .LIMIT(APD_CYCLES)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .tmr(tif.timer)
    );

    dpsc_pkg::dpsc_state_e st_q;
    dpsc_pkg::dpsc_state_e st_d;
    logic [dpsc_pkg::CNT_W-1:0] spin_q;
    logic [dpsc_pkg::CNT_W-1:0] spin_d;
    logic done_q;
    logic done_d;
    logic ign_q;
    logic ign_d;
    logic mval_q;
    logic mval_d;
    logic [2:0] mode_q;
    logic [2:0] mode_d;
    logic [2:0] ps_q;
    logic [2:0] ps_d;
    logic red_q;
    logic red_d;
    logic act_q;
    logic act_d;
    logic spd_q;
    logic spd_d;
    logic busy_q;
    logic busy_d;
    logic restart;
    logic any_reset;

    ////////////////////////////////////////////////////////////////////////
    // Command decode and state transitions
    always_comb begin
        st_d = st_q;
        spin_d = spin_q;
        done_d = 1'b0;
        ign_d = 1'b0;
        mval_d = 1'b0;
        mode_d = mode_q;
        restart = 1'b0;
        any_reset = hw_reset_i || sw_reset_i;
        if (any_reset) begin
            // A reset raises no completion, unlike other commands, and keeps
            // active, idle or standby; an unfinished spin-up is dropped
            restart = 1'b1;
            if (st_q == dpsc_pkg::ST_SLEEP || st_q == dpsc_pkg::ST_SPINUP) begin
                st_d = dpsc_pkg::ST_STANDBY;
            end
            spin_d = dpsc_pkg::CNT_ZERO;
        end else if (st_q == dpsc_pkg::ST_SLEEP) begin
            ign_d = cmd_valid_i;
        end else if (st_q == dpsc_pkg::ST_SPINUP) begin
            // Host must wait for busy to drop; overlapping commands drop
            ign_d = cmd_valid_i;
            restart = 1'b1;
            if (spin_q >= SPINUP_CYCLES - dpsc_pkg::CNT_ONE) begin
                st_d = dpsc_pkg::ST_ACTIVE;
                done_d = 1'b1;
                spin_d = dpsc_pkg::CNT_ZERO;
            end else begin
                spin_d = spin_q + dpsc_pkg::CNT_ONE;
            end
        end else if (cmd_valid_i) begin
            restart = 1'b1;
            done_d = 1'b1;
            case (cmd_code_i)
                dpsc_pkg::OP_IDLE, dpsc_pkg::OP_IDLE_ALT,
                dpsc_pkg::OP_IDLE_IMM, dpsc_pkg::OP_IDLE_IMM_ALT: begin
                    st_d = dpsc_pkg::ST_IDLE;
                end
                dpsc_pkg::OP_STBY, dpsc_pkg::OP_STBY_ALT,
                dpsc_pkg::OP_STBY_IMM, dpsc_pkg::OP_STBY_IMM_ALT: begin
                    st_d = dpsc_pkg::ST_STANDBY;
                end
                dpsc_pkg::OP_SLEEP, dpsc_pkg::OP_SLEEP_ALT: begin
                    st_d = dpsc_pkg::ST_SLEEP;
                end
                dpsc_pkg::OP_CHECK, dpsc_pkg::OP_CHECK_ALT: begin
                    mval_d = 1'b1;
                    mode_d = ps_q;
                end
                default: begin
                    if (cmd_media_i) begin
                        if (st_q == dpsc_pkg::ST_STANDBY) begin
                            // Completion waits until the spindle is back
                            st_d = dpsc_pkg::ST_SPINUP;
                            done_d = 1'b0;
                            spin_d = dpsc_pkg::CNT_ZERO;
                        end else begin
                            st_d = dpsc_pkg::ST_ACTIVE;
                        end
                    end
                end
            endcase
        end else if (tif.expired && (st_q == dpsc_pkg::ST_ACTIVE ||
                st_q == dpsc_pkg::ST_IDLE)) begin
            st_d = dpsc_pkg::ST_STANDBY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power controls follow the next state so they align with it
    always_comb begin
        ps_d = dpsc_pkg::PS_ACTIVE;
        red_d = 1'b0;
        act_d = 1'b1;
        spd_d = 1'b1;
        busy_d = 1'b0;
        case (st_d)
            dpsc_pkg::ST_ACTIVE: begin
                ps_d = dpsc_pkg::PS_ACTIVE;
            end
            dpsc_pkg::ST_IDLE: begin
                ps_d = dpsc_pkg::PS_IDLE;
                red_d = 1'b1;
            end
            dpsc_pkg::ST_STANDBY: begin
                ps_d = dpsc_pkg::PS_STANDBY;
                red_d = 1'b1;
                act_d = 1'b0;
                spd_d = 1'b0;
            end
            dpsc_pkg::ST_SPINUP: begin
                ps_d = dpsc_pkg::PS_SPINUP;
                busy_d = 1'b1;
            end
            dpsc_pkg::ST_SLEEP: begin
                ps_d = dpsc_pkg::PS_SLEEP;
                red_d = 1'b1;
                act_d = 1'b0;
                spd_d = 1'b0;
            end
            default: begin
                ps_d = dpsc_pkg::PS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q <= dpsc_pkg::ST_ACTIVE;
            spin_q <= dpsc_pkg::CNT_ZERO;
            done_q <= 1'b0;
            ign_q <= 1'b0;
            mval_q <= 1'b0;
            mode_q <= dpsc_pkg::PS_ACTIVE;
            ps_q <= dpsc_pkg::PS_ACTIVE;
            red_q <= 1'b0;
            act_q <= 1'b1;
            spd_q <= 1'b1;
            busy_q <= 1'b0;
        end else if (clk_en_i) begin
            st_q <= st_d;
            spin_q <= spin_d;
            done_q <= done_d;
            ign_q <= ign_d;
            mval_q <= mval_d;
            mode_q <= mode_d;
            ps_q <= ps_d;
            red_q <= red_d;
            act_q <= act_d;
            spd_q <= spd_d;
            busy_q <= busy_d;
        end
    end

    assign tif.restart = restart;
    assign tif.enable = apd_enable_i;
    assign cmd_done_o = done_q;
    assign cmd_ignored_o = ign_q;
    assign busy_o = busy_q;
    assign mode_valid_o = mval_q;
    assign mode_o = mode_q;
    assign power_state_o = ps_q;
    assign reduced_power_o = red_q;
    assign actuator_motor_circuit_en_o = act_q;
    assign spindle_run_o = spd_q;
endmodule // dpsc_power_ctrl
`default_nettype wire

// *** dpsc_power_ctrl_sva.sv ***
// Checker for the drive power state controller
`timescale 1ns/100ps
`default_nettype none
module dpsc_power_ctrl_sva #(
    parameter logic [dpsc_pkg::CNT_W-1:0] APD_CYCLES = 32'h0000_0010,
    parameter logic [dpsc_pkg::CNT_W-1:0] SPINUP_CYCLES = 32'h0000_0008
) (
    // Clock, reset, enable
    input wire logic ref_clk_i, rst_i, clk_en_i,
    // Host side
    input wire logic hw_reset_i, sw_reset_i, cmd_valid_i, cmd_media_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic apd_enable_i,
    // Results and power controls
    input wire logic cmd_done_o, cmd_ignored_o, busy_o, mode_valid_o,
    input wire logic [2:0] mode_o, power_state_o,
    input wire logic reduced_power_o, actuator_motor_circuit_en_o,
    input wire logic spindle_run_o
);
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // A command taken with no reset beside it
    wire logic tk = clk_en_i && cmd_valid_i && !hw_reset_i && !sw_reset_i;
    wire logic rs = clk_en_i && (hw_reset_i || sw_reset_i);
    ////////////////////////////////////////////////////////////////////////
    plain_done_a: assert property (tk && !cmd_media_i && power_state_o < 3'h3
        |=> cmd_done_o) else $error("plain command not done");
    media_act_a: assert property (tk && cmd_media_i && power_state_o < 3'h2
        |=> cmd_done_o && power_state_o == dpsc_pkg::PS_ACTIVE)
        else $error("media command left drive inactive");
    // Figure fixed for the eight-cycle spin-up used on the bench
    spin_wait_a: assert property (tk && cmd_media_i && power_state_o == 3'h2
        |=> busy_o && spindle_run_o && !cmd_done_o ##8 cmd_done_o)
        else $error("spin-up answer timing wrong");
    stby_off_a: assert property (power_state_o == dpsc_pkg::PS_STANDBY
        |-> !actuator_motor_circuit_en_o && !spindle_run_o && reduced_power_o)
        else $error("standby left motors powered");
    idle_red_a: assert property (power_state_o == dpsc_pkg::PS_IDLE
        |-> reduced_power_o && spindle_run_o) else $error("idle power wrong");
    idle_in_a: assert property (tk && power_state_o inside {3'h0, 3'h2} &&
        cmd_code_i inside {8'hE3, 8'h97, 8'hE1, 8'h95}
        |=> power_state_o == dpsc_pkg::PS_IDLE) else $error("idle not entered");
    stby_in_a: assert property (tk && power_state_o < 3'h2 &&
        cmd_code_i inside {8'hE2, 8'h96, 8'hE0, 8'h94}
        |=> power_state_o == dpsc_pkg::PS_STANDBY)
        else $error("standby not entered");
    sleep_in_a: assert property (tk && power_state_o < 3'h3 &&
        cmd_code_i inside {8'hE6, 8'h99}
        |=> power_state_o == dpsc_pkg::PS_SLEEP) else $error("sleep not entered");
    sleep_ign_a: assert property (tk && power_state_o == 3'h4
        |=> cmd_ignored_o && !cmd_done_o && power_state_o == 3'h4)
        else $error("command acted on in sleep");
    wake_a: assert property (rs && power_state_o == dpsc_pkg::PS_SLEEP
        |=> power_state_o == dpsc_pkg::PS_STANDBY && !cmd_done_o)
        else $error("reset did not wake to standby");
    check_ans_a: assert property (tk && power_state_o < 3'h3 &&
        cmd_code_i inside {8'hE5, 8'h98}
        |=> mode_valid_o && cmd_done_o && mode_o == $past(power_state_o))
        else $error("check mode answer wrong");
endmodule // dpsc_power_ctrl_sva
bind dpsc_power_ctrl dpsc_power_ctrl_sva #(.APD_CYCLES(APD_CYCLES),
    .SPINUP_CYCLES(SPINUP_CYCLES)) chk_u (.*);
`default_nettype wire

// *** dpsc_host_model.sv ***
// Host model issuing power and media commands and drive resets
`timescale 1ns/100ps
`default_nettype none
module dpsc_host_model (
    input wire logic ref_clk_i,
    output logic hw_reset_o,
    output logic sw_reset_o,
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic cmd_media_o
);
    initial begin
        hw_reset_o = 1'h0;
        sw_reset_o = 1'h0;
        cmd_valid_o = 1'h0;
        cmd_code_o = 8'h00;
        cmd_media_o = 1'h0;
    end
    // One-cycle command strobe
    task automatic send(input logic [7:0] code, input logic media);
        @(posedge ref_clk_i);
        #1;
        cmd_code_o = code;
        cmd_media_o = media;
        cmd_valid_o = 1'h1;
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'h0;
        // Released lines show junk so a stale opcode cannot pass
        cmd_code_o = ~code;
        cmd_media_o = ~media;
    endtask
    // Only way to wake a sleeping drive
    task automatic reset_pulse(input logic hw);
        @(posedge ref_clk_i);
        #1;
        hw_reset_o = hw;
        sw_reset_o = !hw;
        @(posedge ref_clk_i);
        #1;
        hw_reset_o = 1'h0;
        sw_reset_o = 1'h0;
    endtask
endmodule // dpsc_host_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the drive power state controller
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic ref_clk_i, rst_i, apd_enable_i, hw_reset_i, sw_reset_i;
    logic cmd_valid_i, cmd_media_i, cmd_done_o, cmd_ignored_o, busy_o;
    logic [7:0] cmd_code_i;
    logic [2:0] mode_o, power_state_o;
    logic mode_valid_o, reduced_power_o, act_o, spin_o;
    logic clk_en_i;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    initial begin
        ref_clk_i = 1'h0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Short counts keep the run brief
    dpsc_power_ctrl #(.APD_CYCLES(32'h0000_0010),
        .SPINUP_CYCLES(32'h0000_0008)) dut_u (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .clk_en_i(clk_en_i), .hw_reset_i(hw_reset_i),
        .sw_reset_i(sw_reset_i), .cmd_valid_i(cmd_valid_i),
        .cmd_code_i(cmd_code_i), .cmd_media_i(cmd_media_i),
        .apd_enable_i(apd_enable_i), .cmd_done_o(cmd_done_o),
        .cmd_ignored_o(cmd_ignored_o), .busy_o(busy_o),
        .mode_valid_o(mode_valid_o), .mode_o(mode_o),
        .power_state_o(power_state_o), .reduced_power_o(reduced_power_o),
        .actuator_motor_circuit_en_o(act_o), .spindle_run_o(spin_o));
    dpsc_host_model host_u (.ref_clk_i(ref_clk_i), .hw_reset_o(hw_reset_i),
        .sw_reset_o(sw_reset_i), .cmd_valid_o(cmd_valid_i),
        .cmd_code_o(cmd_code_i), .cmd_media_o(cmd_media_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic m, input logic [2:0] s);
        host_u.send(c, m);
        chk({2'h0, cmd_done_o}, 3'h1);
        chk(power_state_o, s);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_idle();
        logic [7:0] codes[4] = '{8'hE3, 8'h97, 8'hE1, 8'h95};
        chk({act_o, spin_o, reduced_power_o}, 3'h6);
        foreach (codes[i]) begin
            cmd(codes[i], 1'h0, dpsc_pkg::PS_IDLE);
            chk({2'h0, reduced_power_o}, 3'h1);
            cmd(8'h20, 1'h1, dpsc_pkg::PS_ACTIVE);
        end
        cmd(8'hE3, 1'h0, dpsc_pkg::PS_IDLE);
        cmd(8'hEC, 1'h0, dpsc_pkg::PS_IDLE);
        host_u.reset_pulse(1'h1);
        chk(power_state_o, dpsc_pkg::PS_IDLE);
    endtask
    task automatic t_standby();
        logic [7:0] codes[4] = '{8'hE2, 8'h96, 8'hE0, 8'h94};
        foreach (codes[i]) begin
            cmd(codes[i], 1'h0, dpsc_pkg::PS_STANDBY);
            chk({1'h0, act_o, spin_o}, 3'h0);
            cmd(8'hE3, 1'h0, dpsc_pkg::PS_IDLE);
        end
        cmd(8'hE2, 1'h0, dpsc_pkg::PS_STANDBY);
        cmd(8'hE5, 1'h0, dpsc_pkg::PS_STANDBY);
        chk(mode_o, dpsc_pkg::PS_STANDBY);
        cmd(8'h98, 1'h0, dpsc_pkg::PS_STANDBY);
        chk({2'h0, mode_valid_o}, 3'h1);
        host_u.reset_pulse(1'h0);
        chk(power_state_o, dpsc_pkg::PS_STANDBY);
    endtask
    task automatic t_spinup();
        host_u.send(8'h20, 1'h1);
        chk({busy_o, act_o, spin_o}, 3'h7);
        host_u.send(8'h21, 1'h1);
        chk({2'h0, cmd_ignored_o}, 3'h1);
        for (int i = 0; i < 20 && cmd_done_o !== 1'h1; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
        chk({busy_o, cmd_done_o, 1'h0}, 3'h2);
        chk(power_state_o, dpsc_pkg::PS_ACTIVE);
    endtask
    task automatic t_sleep();
        logic [7:0] codes[2] = '{8'hE6, 8'h99};
        foreach (codes[i]) begin
            cmd(codes[i], 1'h0, dpsc_pkg::PS_SLEEP);
            host_u.send(8'hE3, 1'h0);
            chk({cmd_ignored_o, cmd_done_o, 1'h0}, 3'h4);
            chk(power_state_o, dpsc_pkg::PS_SLEEP);
            host_u.reset_pulse(i == 0);
            chk(power_state_o, dpsc_pkg::PS_STANDBY);
        end
    endtask
    task automatic t_apd();
        cmd(8'hE3, 1'h0, dpsc_pkg::PS_IDLE);
        apd_enable_i = 1'h1;
        // Sixteen idle edges to expiry, the state follows one edge later
        repeat (16) @(posedge ref_clk_i);
        #1;
        chk(power_state_o, dpsc_pkg::PS_IDLE);
        @(posedge ref_clk_i);
        #1;
        chk(power_state_o, dpsc_pkg::PS_STANDBY);
    endtask
    task automatic t_hold();
        // A frozen block must not act on a command it never took
        clk_en_i = 1'h0;
        host_u.send(8'hE6, 1'h0);
        chk(power_state_o, dpsc_pkg::PS_STANDBY);
        chk({cmd_done_o, cmd_ignored_o, busy_o}, 3'h0);
        clk_en_i = 1'h1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'h1;
        clk_en_i = 1'h1;
        apd_enable_i = 1'h0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        rst_i = 1'h0;
        t_idle();
        t_standby();
        t_spinup();
        t_sleep();
        t_apd();
        t_hold();
        close_out();
    end
    // Run needs about a hundred cycles; a hang is cut off well beyond
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            close_out();
        end
    end
endmodule // tb
`default_nettype wire
